// file: logic/ifel_cfg.svh
/*
 Holds offsets, field positions, reset values and widths for the
 interrupt flag and enable block. Assumes inclusion by bare name.
*/
`ifndef IFEL_CFG_SVH
`define IFEL_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define IFEL_FLAGS_OFFSET     12'h004
`define IFEL_MASK_OFFSET      12'h008
`define IFEL_LEVELS_OFFSET    12'h00c
`define IFEL_CTRL_OFFSET      12'h010
// ****************************************
// Field positions and reset values
// ****************************************
`define IFEL_EDGE_BIT         0
`define IFEL_CRC_BIT          1
`define IFEL_MASK_WMASK       24'h0001df
`define IFEL_MASK_RESET       24'h000000
`define IFEL_CTRL_RESET       32'h00000000
`define IFEL_CTRL_WMASK       32'h00000007
`define IFEL_CTRL_CRC_EN_BIT  0
`define IFEL_CTRL_RISE_BIT    1
`define IFEL_CTRL_FALL_BIT    2
`define IFEL_GPIO_WIDTH       6
`endif

// file: logic/ifel_pkg.sv
/*
 Holds the types of the interrupt flag and enable block.
 Assumes nothing of its surroundings.
*/
package ifel_pkg;
	typedef enum logic [1:0] {
		IFEL_IDLE,
		IFEL_ACCESS
	} ifel_apb_state_type;
endpackage

// file: logic/ifel_top.sv
/*
 Holds the interrupt flags, enable mask and APB slave.
 Assumes a synchronous APB master on pclk and asynchronous gpio pins.
*/
// The APB register port is this design's own decision.
//Contract
//- Checksum flag: set on mismatch, clear on read
//- Edge flag set on selected input edge
//- Edge flag read clear, levels untouched
//- Edge flag sets again after later edges
//- Mask bit zero blocks its flag
//- Mask bit one passes its flag
`timescale 1ns/1ps
`include "ifel_cfg.svh"
module ifel_top #(
	parameter int GPIO_W = `IFEL_GPIO_WIDTH
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [GPIO_W-1:0] gpio_pins,
	input  wire logic [GPIO_W-1:0] gpio_is_input,
	input  wire logic              frame_done,
	input  wire logic              checksum_bad,
	input  wire logic [23:0]       ext_flags,
	output logic                   irq_n
);
	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	logic [GPIO_W-1:0] sync1_reg;
	logic [GPIO_W-1:0] sync2_reg;
	logic [GPIO_W-1:0] input_pin_levels_reg;
	logic [GPIO_W-1:0] edge_hit;
	logic [31:0]       ctrl_reg;
	logic [23:0]       interrupt_enable_mask_reg;
	logic              input_edge_flag_reg;
	logic              checksum_flag_reg;
	logic              levels_valid_reg;
	logic              rd_flags;
	logic              rd_levels;
	logic              wr_access;
	logic              edge_any;
	logic [23:0]       flags_view;
	ifel_pkg::ifel_apb_state_type state_reg;
	localparam logic [23:0] MASK_WMASK = `IFEL_MASK_WMASK;
	localparam logic [31:0] CTRL_WMASK = `IFEL_CTRL_WMASK;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			input_pin_levels_reg <= '0;
			levels_valid_reg <= 1'b0;
		end else begin
			sync1_reg <= gpio_pins;
			sync2_reg <= sync1_reg;
			input_pin_levels_reg <= sync2_reg;
			levels_valid_reg <= 1'b1;
		end
	end

	always_comb begin
		edge_hit = '0;
		if (levels_valid_reg) begin
			edge_hit = gpio_is_input & (
				({GPIO_W{ctrl_reg[`IFEL_CTRL_RISE_BIT]}} &
				 sync2_reg & ~input_pin_levels_reg) |
				({GPIO_W{ctrl_reg[`IFEL_CTRL_FALL_BIT]}} &
				 ~sync2_reg & input_pin_levels_reg));
		end
	end
	assign edge_any = |edge_hit;

	// ****************************************
	// APB slave
	// ****************************************
	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a[11:2] == o[11:2]);
	endfunction

	assign pready = (state_reg == ifel_pkg::IFEL_ACCESS);
	assign rd_flags = pready && !pwrite && hit(paddr, `IFEL_FLAGS_OFFSET);
	assign rd_levels = pready && !pwrite && hit(paddr, `IFEL_LEVELS_OFFSET);
	assign wr_access = pready && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ifel_pkg::IFEL_IDLE;
		end else begin
			case (state_reg)
				ifel_pkg::IFEL_IDLE: begin
					if (psel && !penable) begin
						state_reg <= ifel_pkg::IFEL_ACCESS;
					end
				end
				ifel_pkg::IFEL_ACCESS: begin
					state_reg <= ifel_pkg::IFEL_IDLE;
				end
				default: begin
					state_reg <= ifel_pkg::IFEL_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		flags_view = ext_flags;
		flags_view[`IFEL_EDGE_BIT] = input_edge_flag_reg;
		flags_view[`IFEL_CRC_BIT] = checksum_flag_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !(hit(paddr, `IFEL_FLAGS_OFFSET) ||
				hit(paddr, `IFEL_MASK_OFFSET) ||
				hit(paddr, `IFEL_LEVELS_OFFSET) ||
				hit(paddr, `IFEL_CTRL_OFFSET)) ||
				(pwrite && (hit(paddr, `IFEL_FLAGS_OFFSET) ||
				hit(paddr, `IFEL_LEVELS_OFFSET)));
			if (!pwrite) begin
				if (hit(paddr, `IFEL_FLAGS_OFFSET)) begin
					prdata <= {8'h00, flags_view};
				end else if (hit(paddr, `IFEL_MASK_OFFSET)) begin
					prdata <= {8'h00, interrupt_enable_mask_reg};
				end else if (hit(paddr, `IFEL_LEVELS_OFFSET)) begin
					prdata <= {{(32-GPIO_W){1'b0}},
						input_pin_levels_reg & gpio_is_input};
				end else if (hit(paddr, `IFEL_CTRL_OFFSET)) begin
					prdata <= ctrl_reg;
				end else begin
					prdata <= 32'h00000000;
				end
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

	// ****************************************
	// Writable registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable_mask_reg <= `IFEL_MASK_RESET;
		end else if (wr_access && hit(paddr, `IFEL_MASK_OFFSET)) begin
			for (int b = 0; b < 3; b++) begin
				if (pstrb[b]) begin
					interrupt_enable_mask_reg[b*8 +: 8] <=
						pwdata[b*8 +: 8] & MASK_WMASK[b*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `IFEL_CTRL_RESET;
		end else if (wr_access && hit(paddr, `IFEL_CTRL_OFFSET)) begin
			for (int b = 0; b < 4; b++) begin
				if (pstrb[b]) begin
					ctrl_reg[b*8 +: 8] <=
						pwdata[b*8 +: 8] & CTRL_WMASK[b*8 +: 8];
				end
			end
		end
	end

	// ****************************************
	// Event flags
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_edge_flag_reg <= 1'b0;
		end else if (edge_any) begin
			input_edge_flag_reg <= 1'b1;
		end else if (rd_flags && prdata[`IFEL_EDGE_BIT]) begin
			input_edge_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			checksum_flag_reg <= 1'b0;
		end else if (frame_done && checksum_bad &&
			ctrl_reg[`IFEL_CTRL_CRC_EN_BIT]) begin
			checksum_flag_reg <= 1'b1;
		end else if (rd_flags && prdata[`IFEL_CRC_BIT]) begin
			checksum_flag_reg <= 1'b0;
		end
	end

	// ****************************************
	// Interrupt output
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= ~|(flags_view & interrupt_enable_mask_reg);
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_crc_set;
		@(posedge pclk) disable iff (!presetn)
		frame_done && checksum_bad && ctrl_reg[`IFEL_CTRL_CRC_EN_BIT]
		|=> checksum_flag_reg;
	endproperty
	a_crc_set: assert property (p_crc_set) else $error("crc flag not set");

	property p_crc_off;
		@(posedge pclk) disable iff (!presetn)
		!ctrl_reg[`IFEL_CTRL_CRC_EN_BIT] && !checksum_flag_reg
		|=> !checksum_flag_reg;
	endproperty
	a_crc_off: assert property (p_crc_off) else $error("crc flag while off");

	property p_edge_set;
		@(posedge pclk) disable iff (!presetn)
		edge_any |=> input_edge_flag_reg;
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge flag missed");

	property p_edge_clear;
		@(posedge pclk) disable iff (!presetn)
		rd_flags && prdata[`IFEL_EDGE_BIT] && !edge_any
		|=> !input_edge_flag_reg &&
			input_pin_levels_reg == $past(sync2_reg);
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("bad clear");

	property p_edge_reset;
		@(posedge pclk) disable iff (!presetn)
		rd_levels ##1 edge_any |=> input_edge_flag_reg;
	endproperty
	a_edge_reset: assert property (p_edge_reset) else $error("no reassert");

	property p_masked;
		@(posedge pclk) disable iff (!presetn)
		(flags_view & interrupt_enable_mask_reg) == 24'h000000 |=> irq_n;
	endproperty
	a_masked: assert property (p_masked) else $error("masked irq active");

	property p_enabled;
		@(posedge pclk) disable iff (!presetn)
		(flags_view & interrupt_enable_mask_reg) != 24'h000000 |=> !irq_n;
	endproperty
	a_enabled: assert property (p_enabled) else $error("irq not driven");

	property p_release;
		@(posedge pclk) disable iff (!presetn)
		!irq_n && $fell(|(flags_view & interrupt_enable_mask_reg))
		|=> irq_n;
	endproperty
	a_release: assert property (p_release) else $error("irq not released");
endmodule

// file: tb/ifel_link_model.sv
/*
 Model of the link and pin side: input pins and received frames.
 Assumes a caller that uses its tasks from one process only.
*/
`timescale 1ns/1ps
module ifel_link_model (
	input  wire logic       pclk,
	output logic      [5:0] gpio_pins,
	output logic            frame_done,
	output logic            checksum_bad
);
	initial begin
		gpio_pins = 6'h00;
		frame_done = 1'b0;
		checksum_bad = 1'b0;
	end
	// One-cycle frame pulse, qualifier scrambled once released
	task send_frame(input logic bad);
		@(posedge pclk) frame_done <= 1'b1;
		checksum_bad <= bad;
		@(posedge pclk) frame_done <= 1'b0;
		checksum_bad <= ~bad;
	endtask
	task set_pins(input logic [5:0] v);
		@(posedge pclk) gpio_pins <= v;
	endtask
endmodule

// file: tb/ifel_top_tb_top.sv
/*
 Self-checking bench of the interrupt flag and enable block.
 Assumes the design files and the link model are compiled first.
*/
`timescale 1ns/1ps
`include "ifel_cfg.svh"
module ifel_top_tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0]  pstrb = 4'hf;
	logic [23:0] ext_flags = 24'h000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  gpio_pins;
	logic [5:0]  gpio_is_input = 6'h3f;
	logic        frame_done;
	logic        checksum_bad;
	logic        irq_n;
	logic [31:0] rv;
	logic        ev;
	int          errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	ifel_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpio_pins(gpio_pins),
		.gpio_is_input(gpio_is_input), .frame_done(frame_done),
		.checksum_bad(checksum_bad), .ext_flags(ext_flags),
		.irq_n(irq_n));
	ifel_link_model u_link (.pclk(pclk), .gpio_pins(gpio_pins),
		.frame_done(frame_done), .checksum_bad(checksum_bad));
	// ****************************************
	// Clock, timeout and shared tasks
	// ****************************************
	initial begin
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		forever begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_reset;
		apb(1'b0, `IFEL_MASK_OFFSET, 32'h0);
		chk("mask_reset", 32'h0, rv);
		chk("irq_idle", 32'h1, {31'h0, irq_n});
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, ev});
		apb(1'b1, `IFEL_FLAGS_OFFSET, 32'h3);
		chk("ro_write_err", 32'h1, {31'h0, ev});
		$display("test reset done");
	endtask
	task t_crc;
		u_link.send_frame(1'b1);
		wt(3);
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("crc_off", 32'h0, rv);
		apb(1'b1, `IFEL_CTRL_OFFSET, 32'h3);
		u_link.send_frame(1'b0);
		u_link.send_frame(1'b1);
		wt(3);
		chk("irq_masked", 32'h1, {31'h0, irq_n});
		apb(1'b1, `IFEL_MASK_OFFSET, 32'hffffffff);
		apb(1'b0, `IFEL_MASK_OFFSET, 32'h0);
		chk("mask_bits", 32'h000001df, rv);
		apb(1'b1, `IFEL_MASK_OFFSET, 32'h2);
		wt(3);
		chk("irq_on", 32'h0, {31'h0, irq_n});
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("crc_set", 32'h2, rv);
		wt(3);
		chk("irq_off", 32'h1, {31'h0, irq_n});
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("crc_clr", 32'h0, rv);
		$display("test checksum done");
	endtask
	task t_edge;
		apb(1'b1, `IFEL_MASK_OFFSET, 32'h1);
		u_link.set_pins(6'h01);
		wt(6);
		chk("irq_edge", 32'h0, {31'h0, irq_n});
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("edge_set", 32'h1, rv);
		apb(1'b0, `IFEL_LEVELS_OFFSET, 32'h0);
		chk("levels", 32'h01, rv);
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("edge_clr", 32'h0, rv);
		u_link.set_pins(6'h03);
		wt(6);
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("edge_again", 32'h1, rv);
		u_link.set_pins(6'h01);
		gpio_is_input <= 6'h3d;
		wt(6);
		u_link.set_pins(6'h03);
		wt(6);
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("edge_filter", 32'h0, rv);
		chk("irq_rel", 32'h1, {31'h0, irq_n});
		$display("test edge done");
	endtask
	task t_ext;
		gpio_is_input <= 6'h3f;
		apb(1'b1, `IFEL_CTRL_OFFSET, 32'hffffffff);
		apb(1'b0, `IFEL_CTRL_OFFSET, 32'h0);
		chk("ctrl_bits", 32'h7, rv);
		apb(1'b1, `IFEL_CTRL_OFFSET, 32'h4);
		u_link.set_pins(6'h02);
		wt(6);
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("edge_fall", 32'h1, rv);
		u_link.set_pins(6'h03);
		wt(6);
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("rise_unsel", 32'h0, rv);
		ext_flags <= 24'h000104;
		wt(3);
		chk("ext_masked", 32'h1, {31'h0, irq_n});
		pstrb <= 4'h2;
		apb(1'b1, `IFEL_MASK_OFFSET, 32'h00000100);
		pstrb <= 4'hf;
		apb(1'b0, `IFEL_MASK_OFFSET, 32'h0);
		chk("mask_lane", 32'h101, rv);
		wt(3);
		chk("ext_irq", 32'h0, {31'h0, irq_n});
		apb(1'b0, `IFEL_FLAGS_OFFSET, 32'h0);
		chk("ext_view", 32'h104, rv);
		ext_flags <= 24'h000000;
		wt(3);
		chk("ext_rel", 32'h1, {31'h0, irq_n});
		$display("test external done");
	endtask
	initial begin
		wt(4);
		presetn <= 1'b1;
		t_reset();
		t_crc();
		t_edge();
		t_ext();
		report_and_stop();
	end
endmodule
